// ---- rtl/aadb_map.svh ----
// constants for the adjust, divide, decrement and loop-branch datapath
`ifndef AADB_MAP_SVH
`define AADB_MAP_SVH

// packed decimal digit limit and correction constants
`define AADB_BCD_DIGIT_MAX 4'h9
`define AADB_ADD_LO_FIX    8'h06
`define AADB_ADD_HI_FIX    8'h60
`define AADB_SUB_H_FIX     8'hFA
`define AADB_SUB_C_FIX     8'hA0
`define AADB_SUB_HC_FIX    8'h9A

// instruction bit positions of the interrupt-kind selectors
`define AADB_NVI_BIT       0
`define AADB_VI_BIT        1

// sign bit positions that bound the quotient range checks
`define AADB_WORD_C_MSB    6'h0F
`define AADB_WORD_V_MSB    6'h10
`define AADB_LONG_C_MSB    6'h1F
`define AADB_LONG_V_MSB    6'h20

// divider iteration counts, one quotient bit per cycle
`define AADB_WORD_STEPS    7'h20
`define AADB_LONG_STEPS    7'h40

`endif

// ---- rtl/aadb_pkg.sv ----
// types shared by the adjust, divide, decrement and loop-branch datapath
package aadb_pkg;

	// operation selected by the decoder
	typedef enum logic [2:0] {
		op_none,
		op_decimal_adjust_byte,
		op_subtract_small_constant,
		op_mask_interrupt_kinds,
		op_signed_quotient_word,
		op_signed_quotient_long,
		op_count_loop_branch_word,
		op_count_loop_branch_byte
	} aadb_op_t;

	// condition flags of the flag_control_word
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
	} aadb_flags_t;

	// decoded request
	typedef struct packed {
		logic       valid;
		aadb_op_t   op;
		logic       byte_mode;
		logic [3:0] imm;
		logic [1:0] int_sel;
		logic [6:0] disp;
	} aadb_req_t;

	// registered answer
	typedef struct packed {
		logic        done;
		logic        wr_en;
		logic [63:0] result;
		aadb_flags_t flags;
		logic        pc_load;
		logic [15:0] pc;
		logic        fcw_wr;
		logic        nonvectored_int_enable;
		logic        vi;
		logic        trap;
	} aadb_rsp_t;

	// sequencer states
	typedef enum logic {
		st_idle,
		st_divide
	} aadb_state_t;

endpackage : aadb_pkg

// ---- rtl/aadb_divider.sv ----
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`include "aadb_map.svh"

module aadb_divider #(
	parameter int DVD_W = 64,
	parameter int DVS_W = 32,
	parameter int CNT_W = 7
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             start_in,
	input  wire logic             long_in,
	input  wire logic [DVD_W-1:0] dividend_in,
	input  wire logic [DVS_W-1:0] divisor_in,
	output logic                  done_out,
	output logic      [DVD_W-1:0] quotient_out,
	output logic      [DVS_W-1:0] remainder_out
);

	logic [CNT_W-1:0] cnt_ff;
	logic [DVS_W-1:0] dvs_ff;
	logic [DVS_W:0]   shifted;
	logic [DVS_W+1:0] diff;
	logic             fits;

	// trial subtraction of the divisor from the shifted partial remainder
	assign shifted = {remainder_out, quotient_out[DVD_W-1]};
	assign diff    = {1'h0, shifted} - {2'h0, dvs_ff};
	assign fits    = ~diff[DVS_W+1];

	// word dividends are left aligned so both widths shift out of the top
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			cnt_ff        <= '0;
			dvs_ff        <= '0;
			quotient_out  <= '0;
			remainder_out <= '0;
		end else if (start_in) begin
			cnt_ff        <= long_in ? `AADB_LONG_STEPS : `AADB_WORD_STEPS;
			dvs_ff        <= divisor_in;
			remainder_out <= '0;
			quotient_out  <= long_in ? dividend_in :
				{dividend_in[DVS_W-1:0], {DVS_W{1'h0}}};
		end else if (cnt_ff != '0) begin
			cnt_ff        <= cnt_ff - {{(CNT_W-1){1'h0}}, 1'h1};
			quotient_out  <= {quotient_out[DVD_W-2:0], fits};
			remainder_out <= fits ? diff[DVS_W-1:0] : shifted[DVS_W-1:0];
		end
	end

	// one-cycle pulse as the last quotient bit lands
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			done_out <= 1'h0;
		end else begin
			done_out <= (cnt_ff == {{(CNT_W-1){1'h0}}, 1'h1}) && !start_in;
		end
	end

endmodule : aadb_divider

// ---- rtl/alu_adjust_div_dec_branch.sv ----
// execution datapath: decimal adjust, decrement, interrupt mask, divide, loop
`timescale 1ns/10ps
`include "aadb_map.svh"

module alu_adjust_div_dec_branch (
	input  wire logic                sys_clk_in,
	input  wire logic                rst_b_in,
	input  aadb_pkg::aadb_req_t      req_in,
	input  wire logic [63:0]         dst_in,
	input  wire logic [31:0]         src_in,
	input  wire logic [15:0]         pc_in,
	input  aadb_pkg::aadb_flags_t    flags_in,
	input  wire logic                nvi_in,
	input  wire logic                vi_in,
	input  wire logic                privileged_in,
	output logic                     busy_out,
	output aadb_pkg::aadb_rsp_t      rsp_out
);
	import aadb_pkg::*;

	// two's complement of a long-long value
	function automatic logic [63:0] neg64(input logic [63:0] v);
		return ~v + 64'h1;
	endfunction : neg64

	// magnitude of a signed long value, fits unsigned even for the minimum
	function automatic logic [31:0] abs32(input logic [31:0] v);
		return v[31] ? ~v + 32'h1 : v;
	endfunction : abs32

	// true when bits msb upward all equal, i.e. the value fits below msb
	function automatic logic fits_below(input logic [63:0] q,
		input logic [5:0] msb);
		logic [63:0] mask;
		mask = ~64'h0 << msb;
		return ((q & mask) == 64'h0) || ((q & mask) == mask);
	endfunction : fits_below

	// decimal correction, returns carry after and the adjusted byte
	function automatic logic [8:0] bcd_adjust(input logic [7:0] b,
		input logic c, input logic h, input logic sub);
		logic [7:0] fix;
		logic       lo_fix;
		logic       hi_fix;
		fix    = 8'h00;
		lo_fix = h || (b[3:0] > `AADB_BCD_DIGIT_MAX);
		hi_fix = c || (b[7:4] > `AADB_BCD_DIGIT_MAX) ||
			((b[7:4] == `AADB_BCD_DIGIT_MAX) && (b[3:0] > `AADB_BCD_DIGIT_MAX));
		if (sub) begin
			if (c && h) begin
				fix = `AADB_SUB_HC_FIX;
			end else if (c) begin
				fix = `AADB_SUB_C_FIX;
			end else if (h) begin
				fix = `AADB_SUB_H_FIX;
			end
			return {c, b + fix};
		end
		if (lo_fix) begin
			fix = fix | `AADB_ADD_LO_FIX;
		end
		if (hi_fix) begin
			fix = fix | `AADB_ADD_HI_FIX;
		end
		return {hi_fix, b + fix};
	endfunction : bcd_adjust

	aadb_state_t state_ff;
	aadb_rsp_t   rsp_ff;
	aadb_rsp_t   nxt_rsp;
	aadb_rsp_t   div_rsp;
	logic        busy_ff;
	logic        accept;
	logic        div_go;
	logic        div_done;
	logic        is_long;
	logic [63:0] dvd;
	logic [63:0] dvd_mag;
	logic [31:0] dvs;
	logic [31:0] dvs_mag;
	logic [31:0] hi_half;
	logic        dvs_zero;
	logic        div_abort;
	logic [63:0] q_mag;
	logic [31:0] r_mag;
	logic [63:0] quo;
	logic [31:0] rem;
	logic        ctx_long_ff;
	logic        ctx_qneg_ff;
	logic        ctx_rneg_ff;
	logic [63:0] ctx_dst_ff;
	aadb_flags_t ctx_flags_ff;
	logic [8:0]  dab_val;
	logic [4:0]  dec_k;
	logic [15:0] dec_w;
	logic [7:0]  dec_b;
	logic [15:0] loop_w;
	logic [7:0]  loop_b;
	logic        loop_nz;
	logic [15:0] loop_pc;

	assign accept   = req_in.valid && (state_ff == st_idle);
	assign busy_out = busy_ff;
	assign rsp_out  = rsp_ff;

	// adjust direction follows the D flag left by the preceding add or
	// subtract; garbage in gives garbage out, no detection is attempted
	assign dab_val = bcd_adjust(dst_in[7:0], flags_in.c, flags_in.h,
		flags_in.d);

	// instruction field 0..15 stands for 1..16
	assign dec_k = {1'h0, req_in.imm} + 5'h01;
	assign dec_w = dst_in[15:0] - {11'h000, dec_k};
	assign dec_b = dst_in[7:0] - {3'h0, dec_k};

	// counter decrement and backward target from the following address
	assign loop_w  = dst_in[15:0] - 16'h0001;
	assign loop_b  = dst_in[7:0] - 8'h01;
	assign loop_nz = (req_in.op == op_count_loop_branch_byte) ?
		(loop_b != 8'h00) : (loop_w != 16'h0000);
	// only the offset moves, the segment number is held elsewhere
	assign loop_pc = pc_in - {8'h00, req_in.disp, 1'h0};

	// operand forms; register pairs arrive already aligned by the issuer
	assign is_long = (req_in.op == op_signed_quotient_long);
	assign dvd     = is_long ? dst_in :
		{{32{dst_in[31]}}, dst_in[31:0]};
	assign dvs     = is_long ? src_in : {{16{src_in[15]}}, src_in[15:0]};
	assign hi_half = is_long ? dst_in[63:32] :
		{{16{dst_in[31]}}, dst_in[31:16]};
	assign dvd_mag = dvd[63] ? neg64(dvd) : dvd;
	assign dvs_mag = abs32(dvs);
	assign dvs_zero  = (dvs == 32'h0000_0000);
	// early abort saves the full iteration when the high half exceeds the divisor in magnitude
	assign div_abort = abs32(hi_half) > dvs_mag;

	// immediate answers for every single-cycle operation
	always_comb begin
		nxt_rsp        = '0;
		nxt_rsp.result = dst_in;
		nxt_rsp.flags  = flags_in;
		nxt_rsp.pc     = pc_in;
		nxt_rsp.nonvectored_int_enable    = nvi_in;
		nxt_rsp.vi     = vi_in;
		div_go         = 1'h0;
		if (accept) begin
			nxt_rsp.done = 1'h1;
			case (req_in.op)
				op_decimal_adjust_byte: begin
					nxt_rsp.wr_en       = 1'h1;
					nxt_rsp.result[7:0] = dab_val[7:0];
					nxt_rsp.flags.c     = dab_val[8];
					nxt_rsp.flags.z     = (dab_val[7:0] == 8'h00);
					nxt_rsp.flags.s     = dab_val[7];
				end
				op_subtract_small_constant: begin
					nxt_rsp.wr_en = 1'h1;
					if (req_in.byte_mode) begin
						nxt_rsp.result[7:0] = dec_b;
						nxt_rsp.flags.z     = (dec_b == 8'h00);
						nxt_rsp.flags.s     = dec_b[7];
						nxt_rsp.flags.v     = dec_b[7] != dst_in[7];
					end else begin
						nxt_rsp.result[15:0] = dec_w;
						nxt_rsp.flags.z      = (dec_w == 16'h0000);
						nxt_rsp.flags.s      = dec_w[15];
						nxt_rsp.flags.v      = dec_w[15] != dst_in[15];
					end
				end
				op_mask_interrupt_kinds: begin
					// flags pass through untouched in both branches
					if (privileged_in) begin
						nxt_rsp.fcw_wr = 1'h1;
						if (!req_in.int_sel[`AADB_NVI_BIT]) begin
							nxt_rsp.nonvectored_int_enable = 1'h0;
						end
						if (!req_in.int_sel[`AADB_VI_BIT]) begin
							nxt_rsp.vi = 1'h0;
						end
					end else begin
						nxt_rsp.trap = 1'h1;
					end
				end
				op_signed_quotient_word,
				op_signed_quotient_long: begin
					nxt_rsp.flags.c = 1'h0;
					if (dvs_zero) begin
						nxt_rsp.flags.v = 1'h1;
						nxt_rsp.flags.z = 1'h1;
						nxt_rsp.flags.s = dvs[31];
					end else if (div_abort) begin
						nxt_rsp.flags.v = 1'h1;
						nxt_rsp.flags.z = 1'h0;
						nxt_rsp.flags.s = dvs[31];
					end else begin
						nxt_rsp.done = 1'h0;
						div_go       = 1'h1;
					end
				end
				op_count_loop_branch_word,
				op_count_loop_branch_byte: begin
					// flags field already holds flags_in unchanged
					nxt_rsp.wr_en = 1'h1;
					if (req_in.op == op_count_loop_branch_byte) begin
						nxt_rsp.result[7:0] = loop_b;
					end else begin
						nxt_rsp.result[15:0] = loop_w;
					end
					nxt_rsp.pc_load = loop_nz;
					if (loop_nz) begin
						nxt_rsp.pc = loop_pc;
					end
				end
				default: begin
				end
			endcase
		end
	end

	aadb_divider #(
		.DVD_W (64),
		.DVS_W (32),
		.CNT_W (7)
	) u_divider (
		.sys_clk_in    (sys_clk_in),
		.rst_b_in      (rst_b_in),
		.start_in      (div_go),
		.long_in       (is_long),
		.dividend_in   (dvd_mag),
		.divisor_in    (dvs_mag),
		.done_out      (div_done),
		.quotient_out  (q_mag),
		.remainder_out (r_mag)
	);

	// operand context held while the divider iterates
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			ctx_long_ff  <= 1'h0;
			ctx_qneg_ff  <= 1'h0;
			ctx_rneg_ff  <= 1'h0;
			ctx_dst_ff   <= '0;
			ctx_flags_ff <= '0;
		end else if (div_go) begin
			ctx_long_ff  <= is_long;
			ctx_qneg_ff  <= dvd[63] ^ dvs[31];
			ctx_rneg_ff  <= dvd[63];
			ctx_dst_ff   <= dst_in;
			ctx_flags_ff <= flags_in;
		end
	end

	// sign restore and range checks on the finished quotient
	assign quo = ctx_qneg_ff ? neg64(q_mag) : q_mag;
	assign rem = ctx_rneg_ff ? ~r_mag + 32'h1 : r_mag;

	always_comb begin
		div_rsp         = '0;
		div_rsp.done    = 1'h1;
		div_rsp.pc      = pc_in;
		div_rsp.nonvectored_int_enable     = nvi_in;
		div_rsp.vi      = vi_in;
		div_rsp.flags   = ctx_flags_ff;
		div_rsp.flags.c = !fits_below(quo, ctx_long_ff ?
			`AADB_LONG_C_MSB : `AADB_WORD_C_MSB);
		div_rsp.flags.v = !fits_below(quo, ctx_long_ff ?
			`AADB_LONG_V_MSB : `AADB_WORD_V_MSB);
		div_rsp.flags.z = (quo == 64'h0);
		div_rsp.flags.s = quo[63];
		div_rsp.wr_en   = !div_rsp.flags.v;
		// divisor is never a destination; only the dividend slots change
		if (ctx_long_ff) begin
			div_rsp.result = {rem, quo[31:0]};
		end else begin
			div_rsp.result = {ctx_dst_ff[63:32], rem[15:0],
				quo[15:0]};
		end
	end

	// sequencer: requests are ignored while a division is in flight
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_ff <= st_idle;
			busy_ff  <= 1'h0;
		end else begin
			case (state_ff)
				st_idle: begin
					if (div_go) begin
						state_ff <= st_divide;
						busy_ff  <= 1'h1;
					end
				end
				st_divide: begin
					if (div_done) begin
						state_ff <= st_idle;
						busy_ff  <= 1'h0;
					end
				end
				default: begin
					state_ff <= st_idle;
					busy_ff  <= 1'h0;
				end
			endcase
		end
	end

	// answer register, done is a single-cycle pulse
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			rsp_ff <= '0;
		end else if ((state_ff == st_divide) && div_done) begin
			rsp_ff <= div_rsp;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence dab_req_s;
		accept && (req_in.op == op_decimal_adjust_byte);
	endsequence

	sequence div_go_s;
		accept && (req_in.op == op_signed_quotient_long) &&
			!dvs_zero && !div_abort;
	endsequence

	sequence div_end_s;
		rsp_ff.done && (state_ff == st_idle);
	endsequence

	adjust_flags_keep_a: assert property (dab_req_s |=> rsp_ff.done &&
		(rsp_ff.flags.v == $past(flags_in.v)) &&
		(rsp_ff.flags.h == $past(flags_in.h)) &&
		(rsp_ff.flags.z == (rsp_ff.result[7:0] == 8'h00)))
		else $error("adjust flags wrong");

	adjust_sub_fix_a: assert property (dab_req_s and (flags_in.d &&
		flags_in.c && !flags_in.h) |=> (rsp_ff.result[7:0] ==
		$past(dst_in[7:0]) + 8'hA0) && rsp_ff.flags.c)
		else $error("subtract adjust wrong");

	adjust_add_none_a: assert property (dab_req_s and (!flags_in.d &&
		!flags_in.c && !flags_in.h && (dst_in[7:4] < 4'hA) &&
		(dst_in[3:0] < 4'hA)) |=> (rsp_ff.result[7:0] ==
		$past(dst_in[7:0])) && !rsp_ff.flags.c)
		else $error("add adjust changed valid digits");

	dec_word_value_a: assert property (accept &&
		(req_in.op == op_subtract_small_constant) && !req_in.byte_mode
		|=> (rsp_ff.result[15:0] == $past(dst_in[15:0]) -
		{12'h000, $past(req_in.imm)} - 16'h0001) &&
		(rsp_ff.flags.c == $past(flags_in.c)))
		else $error("decrement value wrong");

	mask_enables_a: assert property (accept && privileged_in &&
		(req_in.op == op_mask_interrupt_kinds) |=> rsp_ff.fcw_wr &&
		(rsp_ff.nonvectored_int_enable == $past(nvi_in && req_in.int_sel[0])) &&
		(rsp_ff.vi == $past(vi_in && req_in.int_sel[1])) &&
		(rsp_ff.flags == $past(flags_in)))
		else $error("mask enables wrong");

	mask_trap_a: assert property (accept && !privileged_in &&
		(req_in.op == op_mask_interrupt_kinds) |=> rsp_ff.trap &&
		!rsp_ff.fcw_wr && !rsp_ff.wr_en)
		else $error("unprivileged mask not trapped");

	div_zero_a: assert property (accept && dvs_zero &&
		((req_in.op == op_signed_quotient_word) || is_long)
		|=> rsp_ff.done && rsp_ff.flags.v && rsp_ff.flags.z &&
		!rsp_ff.wr_en && !busy_out)
		else $error("zero divisor not flagged");

	div_abort_a: assert property (accept && !dvs_zero && div_abort &&
		is_long |=> rsp_ff.flags.v && !rsp_ff.flags.z &&
		(rsp_ff.flags.s == $past(src_in[31])))
		else $error("abort flags wrong");

	div_finish_a: assert property (div_go_s |=> busy_out[*8]
		##[50:62] div_end_s)
		else $error("long divide did not finish in time");

	loop_branch_a: assert property (accept &&
		(req_in.op == op_count_loop_branch_word) &&
		(dst_in[15:0] != 16'h0001) |=> rsp_ff.pc_load &&
		(rsp_ff.pc == $past(pc_in) - {8'h00, $past(req_in.disp), 1'h0}) &&
		(rsp_ff.flags == $past(flags_in)))
		else $error("loop branch wrong");

	loop_fall_a: assert property (accept &&
		(req_in.op == op_count_loop_branch_byte) &&
		(dst_in[7:0] == 8'h01) |=> !rsp_ff.pc_load &&
		(rsp_ff.result[7:0] == 8'h00))
		else $error("loop fell through wrongly");

endmodule : alu_adjust_div_dec_branch

// ---- verification/test_alu_adjust_div_dec_branch.sv ----
// self-checking testbench for the adjust, divide, decrement and loop datapath
`timescale 1ns/10ps

module test_alu_adjust_div_dec_branch;
	import aadb_pkg::*;

	// one stimulus row beside the answer it should give
	typedef struct {
		aadb_op_t    op;
		logic        bm;
		logic [3:0]  imm;
		logic [1:0]  isel;
		logic [6:0]  disp;
		logic [63:0] dst;
		logic [31:0] src;
		logic [15:0] pc;
		logic [5:0]  fl;
		logic [2:0]  iv;
		logic [63:0] res;
		logic [5:0]  efl;
		logic [5:0]  fm;
		logic [3:0]  ctl;
		logic [15:0] epc;
		logic [1:0]  eiv;
	} aadb_row_t;

	localparam int       n_rows = 32;
	localparam aadb_op_t k_adj  = op_decimal_adjust_byte;
	localparam aadb_op_t k_dec  = op_subtract_small_constant;
	localparam aadb_op_t k_msk  = op_mask_interrupt_kinds;
	localparam aadb_op_t k_dvw  = op_signed_quotient_word;
	localparam aadb_op_t k_dvl  = op_signed_quotient_long;
	localparam aadb_op_t k_lpw  = op_count_loop_branch_word;
	localparam aadb_op_t k_lpb  = op_count_loop_branch_byte;

	logic        sys_clk_in;
	logic        rst_b_in;
	aadb_req_t   req;
	logic [63:0] dst;
	logic [31:0] src;
	logic [15:0] pc;
	aadb_flags_t flags;
	logic        nonvectored_int_enable;
	logic        vi;
	logic        priv;
	logic        busy;
	aadb_rsp_t   rsp;
	aadb_rsp_t   got_q [$];
	aadb_rsp_t   r;
	aadb_row_t   rows [n_rows];
	aadb_row_t   w;
	int          fails = 0;
	int          n_compared = 0;
	int          k;

	alu_adjust_div_dec_branch i_alu_adjust_div_dec_branch (
		.sys_clk_in    (sys_clk_in),
		.rst_b_in      (rst_b_in),
		.req_in        (req),
		.dst_in        (dst),
		.src_in        (src),
		.pc_in         (pc),
		.flags_in      (flags),
		.nvi_in        (nonvectored_int_enable),
		.vi_in         (vi),
		.privileged_in (priv),
		.busy_out      (busy),
		.rsp_out       (rsp)
	);

	// 10 MHz clock
	always #50 sys_clk_in = ~sys_clk_in;

	// collect answers at the edge, where the registered pulse is settled
	always @(posedge sys_clk_in) begin
		if (rsp.done === 1'b1) begin
			got_q.push_back(rsp);
		end
	end

	task automatic check(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	// raise a request just after an edge and leave it up
	task automatic present(input aadb_row_t v);
		@(posedge sys_clk_in);
		req   <= '{1'h1, v.op, v.bm, v.imm, v.isel, v.disp};
		dst   <= v.dst;
		src   <= v.src;
		pc    <= v.pc;
		flags <= aadb_flags_t'(v.fl);
		priv  <= v.iv[2];
		nonvectored_int_enable   <= v.iv[1];
		vi    <= v.iv[0];
	endtask : present

	task automatic drop_req;
		@(posedge sys_clk_in);
		req.valid <= 1'h0;
	endtask : drop_req

	// bounded wait; a missing answer counts against the run
	task automatic wait_rsp(input int n);
		int i;
		for (i = 0; i < 100 && got_q.size() < n; i++) begin
			@(posedge sys_clk_in);
			#1;
		end
		if (got_q.size() < n) begin
			fails++;
			$display("MISMATCH answers expected %0d seen %0d", n, got_q.size());
		end
	endtask : wait_rsp

	// watchdog: the whole run needs about five hundred cycles
	initial begin
		#500000;
		fails++;
		tally_and_finish();
	end

	initial begin
		sys_clk_in = 1'h0;
		rst_b_in   = 1'h0;
		req        = '0;
		dst        = 64'h0;
		src        = 32'h0;
		pc         = 16'h0;
		flags      = '0;
		nonvectored_int_enable        = 1'h0;
		vi         = 1'h0;
		priv       = 1'h0;
		// byte adjust after add and subtract
		// decrement by field plus one
		// all four mask selections, then unprivileged
		// dividend images are whole aligned pairs and quads
		// loop branch taken, falling through, byte wrap
		rows = '{
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h443C,32'h0,16'h0,6'h1C,3'h7,
			64'h4442,6'h04,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h41,32'h0,16'h0,6'h01,3'h7,
			64'h47,6'h01,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'hA5,32'h0,16'h0,6'h00,3'h7,
			64'h05,6'h20,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h15,32'h0,16'h0,6'h20,3'h7,
			64'h75,6'h00,6'h1F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h0F,32'h0,16'h0,6'h03,3'h7,
			64'h09,6'h03,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h90,32'h0,16'h0,6'h22,3'h7,
			64'h30,6'h22,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'hFF,32'h0,16'h0,6'h23,3'h7,
			64'h99,6'h2B,6'h3F,4'h8,16'h0,2'h0},
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h00,32'h0,16'h0,6'h02,3'h7,
			64'h00,6'h12,6'h3F,4'h8,16'h0,2'h0},
		'{k_dec,1'h0,4'h0,2'h0,7'h0,64'h2A,32'h0,16'h0,6'h23,3'h7,
			64'h29,6'h23,6'h3F,4'h8,16'h0,2'h0},
		'{k_dec,1'h0,4'hF,2'h0,7'h0,64'hFFFF_0000_0000_8005,32'h0,16'h0,
			6'h00,3'h7,64'hFFFF_0000_0000_7FF5,6'h04,6'h3F,4'h8,16'h0,2'h0},
		'{k_dec,1'h1,4'h4,2'h0,7'h0,64'hAB05,32'h0,16'h0,6'h00,3'h7,
			64'hAB00,6'h10,6'h3F,4'h8,16'h0,2'h0},
		'{k_dec,1'h1,4'h3,2'h0,7'h0,64'h03,32'h0,16'h0,6'h00,3'h7,
			64'hFF,6'h0C,6'h3F,4'h8,16'h0,2'h0},
		'{k_msk,1'h0,4'h0,2'h0,7'h0,64'h0,32'h0,16'h0,6'h3F,3'h7,
			64'h0,6'h3F,6'h3F,4'h2,16'h0,2'h0},
		'{k_msk,1'h0,4'h0,2'h1,7'h0,64'h0,32'h0,16'h0,6'h3F,3'h7,
			64'h0,6'h3F,6'h3F,4'h2,16'h0,2'h2},
		'{k_msk,1'h0,4'h0,2'h2,7'h0,64'h0,32'h0,16'h0,6'h3F,3'h7,
			64'h0,6'h3F,6'h3F,4'h2,16'h0,2'h1},
		'{k_msk,1'h0,4'h0,2'h3,7'h0,64'h0,32'h0,16'h0,6'h3F,3'h4,
			64'h0,6'h3F,6'h3F,4'h2,16'h0,2'h0},
		'{k_msk,1'h0,4'h0,2'h0,7'h0,64'h0,32'h0,16'h0,6'h3F,3'h3,
			64'h0,6'h3F,6'h3F,4'h1,16'h0,2'h0},
		'{op_none,1'h0,4'h0,2'h0,7'h0,64'h0,32'h0,16'h0,6'h15,3'h7,
			64'h0,6'h15,6'h3F,4'h0,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'hDEAD_BEEF_0000_0022,32'h6,16'h0,
			6'h03,3'h7,64'hDEAD_BEEF_0004_0005,6'h03,6'h3F,4'h8,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'h22,32'hFFFA,16'h0,6'h00,3'h7,
			64'h0004_FFFB,6'h08,6'h3F,4'h8,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'h8000,32'h1,16'h0,6'h00,3'h7,
			64'h8000,6'h20,6'h3F,4'h8,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'h22,32'h0,16'h0,6'h00,3'h7,
			64'h0,6'h14,6'h3C,4'h0,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'h0010_0000,32'hFFFB,16'h0,6'h03,3'h7,
			64'h0,6'h0F,6'h2F,4'h0,16'h0,2'h0},
		'{k_dvw,1'h0,4'h0,2'h0,7'h0,64'h0005_0000,32'h5,16'h0,6'h00,3'h7,
			64'h0,6'h24,6'h27,4'h0,16'h0,2'h0},
		'{k_dvl,1'h0,4'h0,2'h0,7'h0,64'h22,32'h6,16'h0,6'h00,3'h7,
			64'h0000_0004_0000_0005,6'h00,6'h3F,4'h8,16'h0,2'h0},
		'{k_dvl,1'h0,4'h0,2'h0,7'h0,64'h8000_0000,32'h1,16'h0,6'h00,3'h7,
			64'h8000_0000,6'h20,6'h3F,4'h8,16'h0,2'h0},
		'{k_lpw,1'h0,4'h0,2'h0,7'h03,64'h5,32'h0,16'h0100,6'h3F,3'h7,
			64'h4,6'h3F,6'h3F,4'hC,16'h00FA,2'h0},
		'{k_lpw,1'h0,4'h0,2'h0,7'h03,64'h1,32'h0,16'h0100,6'h00,3'h7,
			64'h0,6'h00,6'h3F,4'h8,16'h0,2'h0},
		'{k_lpb,1'h0,4'h0,2'h0,7'h7F,64'hAA00,32'h0,16'h0200,6'h15,3'h7,
			64'hAAFF,6'h15,6'h3F,4'hC,16'h0102,2'h0},
		'{k_lpb,1'h0,4'h0,2'h0,7'h05,64'h0101,32'h0,16'h0200,6'h00,3'h7,
			64'h0100,6'h00,6'h3F,4'h8,16'h0,2'h0},
		// valid digits after an add need no correction
		'{k_adj,1'h0,4'h0,2'h0,7'h0,64'h42,32'h0,16'h0,6'h00,3'h7,
			64'h42,6'h00,6'h3F,4'h8,16'h0,2'h0},
		// long abort: high half larger than a negative divisor
		'{k_dvl,1'h0,4'h0,2'h0,7'h0,64'h0000_0010_0000_0000,32'hFFFF_FFFB,
			16'h0,6'h00,3'h7,64'h0,6'h0C,6'h3F,4'h0,16'h0,2'h0}};
		repeat (8) @(posedge sys_clk_in);
		rst_b_in <= 1'h1;
		#1;
		check("reset done", 64'(rsp.done), 64'h0);
		check("reset busy", 64'(busy), 64'h0);
		check("reset result", rsp.result, 64'h0);
		// ordinary cases, one request at a time
		for (k = 0; k < n_rows; k++) begin
			w = rows[k];
			present(w);
			drop_req();
			wait_rsp(1);
			if (got_q.size() > 0) begin
				r = got_q.pop_front();
				check("write", 64'(r.wr_en), 64'(w.ctl[3]));
				check("pc load", 64'(r.pc_load), 64'(w.ctl[2]));
				check("fcw write", 64'(r.fcw_wr), 64'(w.ctl[1]));
				check("trap", 64'(r.trap), 64'(w.ctl[0]));
				check("flags", 64'(r.flags & w.fm), 64'(w.efl & w.fm));
				if (w.ctl[3]) begin
					check("result", r.result, w.res);
				end
				if (w.ctl[2]) begin
					check("pc", 64'(r.pc), 64'(w.epc));
				end
				if (w.ctl[1]) begin
					check("enables", 64'({r.nonvectored_int_enable, r.vi}), 64'(w.eiv));
				end
			end
			check("busy after", 64'(busy), 64'h0);
		end
		// two decrements on consecutive edges
		present(rows[8]);
		present(rows[9]);
		drop_req();
		wait_rsp(2);
		for (k = 8; k < 10; k++) begin
			if (got_q.size() > 0) begin
				r = got_q.pop_front();
				check("back to back", r.result, rows[k].res);
			end
		end
		// a request while the divider iterates is ignored
		present(rows[18]);
		drop_req();
		repeat (3) @(posedge sys_clk_in);
		#1;
		check("busy", 64'(busy), 64'h1);
		present(rows[8]);
		drop_req();
		wait_rsp(1);
		if (got_q.size() > 0) begin
			r = got_q.pop_front();
			check("divide kept", r.result, rows[18].res);
		end
		repeat (4) @(posedge sys_clk_in);
		#1;
		check("no extra answer", 64'(got_q.size()), 64'h0);
		// reset in mid divide drops the operation
		present(rows[24]);
		drop_req();
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'h0;
		repeat (2) @(posedge sys_clk_in);
		#1;
		check("reset busy", 64'(busy), 64'h0);
		@(posedge sys_clk_in);
		rst_b_in <= 1'h1;
		repeat (80) @(posedge sys_clk_in);
		#1;
		check("stale answer", 64'(got_q.size()), 64'h0);
		tally_and_finish();
	end

endmodule : test_alu_adjust_div_dec_branch
